//--- design/sfcd_pkg.sv
package sfcd_pkg;

  // ------------------------------------------------------------------
  // Command groups and decoded operations
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SFCD_GRP_NONE,
    SFCD_GRP_A,
    SFCD_GRP_B,
    SFCD_GRP_C,
    SFCD_GRP_D,
    SFCD_GRP_PWR
  } sfcd_grp_e;

  typedef enum logic [5:0] {
    SFCD_OP_NONE,
    SFCD_OP_PAGE_RD,
    SFCD_OP_CONT_RD_LEG,
    SFCD_OP_CONT_RD_LF,
    SFCD_OP_CONT_RD_HF,
    SFCD_OP_BUF_RD_LF,
    SFCD_OP_BUF_RD,
    SFCD_OP_BUF_WR,
    SFCD_OP_PROG_ERASE,
    SFCD_OP_PROG_NOERASE,
    SFCD_OP_PAGE_ERASE,
    SFCD_OP_BLOCK_ERASE,
    SFCD_OP_SECTOR_ERASE,
    SFCD_OP_CHIP_ERASE,
    SFCD_OP_PROG_THRU_BUF,
    SFCD_OP_XFER,
    SFCD_OP_COMPARE,
    SFCD_OP_REWRITE,
    SFCD_OP_PROT_EN,
    SFCD_OP_PROT_DIS,
    SFCD_OP_PROT_ERASE,
    SFCD_OP_PROT_PROG,
    SFCD_OP_LOCKDOWN,
    SFCD_OP_PROT_RD,
    SFCD_OP_LOCK_RD,
    SFCD_OP_SEC_PROG,
    SFCD_OP_SEC_RD,
    SFCD_OP_DEEP_PD,
    SFCD_OP_RESUME,
    SFCD_OP_STATUS_RD,
    SFCD_OP_ID_RD
  } sfcd_op_e;

  // ------------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_PAGE_RD      = 8'hD2;
  localparam logic [7:0] OPC_CONT_LEG     = 8'hE8;
  localparam logic [7:0] OPC_CONT_LF      = 8'h03;
  localparam logic [7:0] OPC_CONT_HF      = 8'h0B;
  localparam logic [7:0] OPC_BUF1_RD_LF   = 8'hD1;
  localparam logic [7:0] OPC_BUF2_RD_LF   = 8'hD3;
  localparam logic [7:0] OPC_BUF1_RD      = 8'hD4;
  localparam logic [7:0] OPC_BUF2_RD      = 8'hD6;
  localparam logic [7:0] OPC_BUF1_WR      = 8'h84;
  localparam logic [7:0] OPC_BUF2_WR      = 8'h87;
  localparam logic [7:0] OPC_B1_PROG_E    = 8'h83;
  localparam logic [7:0] OPC_B2_PROG_E    = 8'h86;
  localparam logic [7:0] OPC_B1_PROG_N    = 8'h88;
  localparam logic [7:0] OPC_B2_PROG_N    = 8'h89;
  localparam logic [7:0] OPC_PAGE_ERASE   = 8'h81;
  localparam logic [7:0] OPC_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0] OPC_SECT_ERASE   = 8'h7C;
  localparam logic [7:0] OPC_CHIP_ERASE   = 8'hC7;
  localparam logic [7:0] OPC_B1_THRU      = 8'h82;
  localparam logic [7:0] OPC_B2_THRU      = 8'h85;
  localparam logic [7:0] OPC_B1_XFER      = 8'h53;
  localparam logic [7:0] OPC_B2_XFER      = 8'h55;
  localparam logic [7:0] OPC_B1_CMP       = 8'h60;
  localparam logic [7:0] OPC_B2_CMP       = 8'h61;
  localparam logic [7:0] OPC_B1_REWR      = 8'h58;
  localparam logic [7:0] OPC_B2_REWR      = 8'h59;
  localparam logic [7:0] OPC_DEEP_PD      = 8'hB9;
  localparam logic [7:0] OPC_RESUME       = 8'hAB;
  localparam logic [7:0] OPC_STATUS       = 8'hD7;
  localparam logic [7:0] OPC_ID           = 8'h9F;
  localparam logic [7:0] OPC_PROT_RD      = 8'h32;
  localparam logic [7:0] OPC_LOCK_RD      = 8'h35;
  localparam logic [7:0] OPC_SEC_PROG     = 8'h9B;
  localparam logic [7:0] OPC_SEC_RD       = 8'h77;
  localparam logic [7:0] OPC_LEG_BUF1_RD  = 8'h54;
  localparam logic [7:0] OPC_LEG_BUF2_RD  = 8'h56;
  localparam logic [7:0] OPC_LEG_PAGE_RD  = 8'h52;
  localparam logic [7:0] OPC_LEG_CONT_RD  = 8'h68;
  localparam logic [7:0] OPC_LEG_STATUS   = 8'h57;
  localparam logic [7:0] OPC_PROT_PRE0    = 8'h3D;
  localparam logic [7:0] OPC_PROT_PRE1    = 8'h2A;
  localparam logic [7:0] OPC_PROT_PRE2    = 8'h7F;
  localparam logic [7:0] OPC_PROT_EN      = 8'hA9;
  localparam logic [7:0] OPC_PROT_DIS     = 8'h9A;
  localparam logic [7:0] OPC_PROT_ERASE   = 8'hCF;
  localparam logic [7:0] OPC_PROT_PROG    = 8'hFC;
  localparam logic [7:0] OPC_LOCKDOWN     = 8'h30;

  // ------------------------------------------------------------------
  // Frame layout and counts
  // ------------------------------------------------------------------
  localparam int ADDR_BYTES      = 3;
  localparam int ADDR_RSV_BITS   = 2;
  localparam int ADDR_W          = 22;
  localparam int HF_DUMMY_BYTES  = 1;
  localparam int SCK_DIV         = 2;
  localparam logic [7:0] SPI_IDLE_BYTE = 8'h00;

endpackage : sfcd_pkg

//--- design/sfcd_link_if.sv
interface sfcd_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport host (output cs_n, output sck, output mosi, input miso,
                input miso_oe);
  modport dev  (input cs_n, input sck, input mosi, output miso,
                output miso_oe);
endinterface : sfcd_link_if

//--- design/sfcd_device.sv
module sfcd_device #(
  parameter int BUSY_CYCLES = 64
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  sfcd_link_if.dev                link,
  output logic                    cmd_valid,
  input  wire logic               cmd_ready,
  output sfcd_pkg::sfcd_op_e      cmd_op,
  output sfcd_pkg::sfcd_grp_e     cmd_grp,
  output logic                    cmd_buf2,
  output logic [21:0]             cmd_addr,
  output logic                    busy,
  output logic                    cmd_refused
);

  // ------------------------------------------------------------------
  // Pin synchronisers: three stages, change seen when stage 2 == 3
  // ------------------------------------------------------------------
  logic [2:0] cs_s_reg, sck_s_reg, mosi_s_reg;
  logic       cs_n_q_reg, sck_q_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s_reg   <= 3'h7;
      sck_s_reg  <= 3'h0;
      mosi_s_reg <= 3'h0;
    end else begin
      cs_s_reg   <= {cs_s_reg[1:0], link.cs_n};
      sck_s_reg  <= {sck_s_reg[1:0], link.sck};
      mosi_s_reg <= {mosi_s_reg[1:0], link.mosi};
    end
  end

  // Filtered levels only move when the late stages agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_n_q_reg <= 1'b1;
      sck_q_reg  <= 1'b0;
    end else begin
      if (cs_s_reg[1] == cs_s_reg[2])
        cs_n_q_reg <= cs_s_reg[2];
      if (sck_s_reg[1] == sck_s_reg[2])
        sck_q_reg <= sck_s_reg[2];
    end
  end

  wire sck_rise = (sck_s_reg[1] == sck_s_reg[2]) && sck_s_reg[2] &&
                  !sck_q_reg && !cs_n_q_reg;
  wire frame_end = (cs_s_reg[1] == cs_s_reg[2]) && cs_s_reg[2] &&
                   !cs_n_q_reg;

  // ------------------------------------------------------------------
  // Byte assembly
  // ------------------------------------------------------------------
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] byte0_reg, byte3_reg;
  logic [23:0] addr_sr_reg;
  logic       drop_reg;

  wire [7:0] byte_now   = {shift_reg[6:0], mosi_s_reg[2]};
  wire       byte_done  = sck_rise && (bit_cnt_reg == 3'h7);
  wire       first_byte = byte_done && (byte_cnt_reg == 3'h0);

  // ------------------------------------------------------------------
  // Opcode decode (first byte)
  // ------------------------------------------------------------------
  sfcd_pkg::sfcd_op_e  dec_op;
  logic                dec_b2;
  logic                dec_known;

  always_comb begin
    dec_op    = sfcd_pkg::SFCD_OP_NONE;
    dec_b2    = 1'b0;
    dec_known = 1'b1;
    case (byte_now)
      sfcd_pkg::OPC_PAGE_RD, sfcd_pkg::OPC_LEG_PAGE_RD:
        dec_op = sfcd_pkg::SFCD_OP_PAGE_RD;
      sfcd_pkg::OPC_CONT_LEG, sfcd_pkg::OPC_LEG_CONT_RD:
        dec_op = sfcd_pkg::SFCD_OP_CONT_RD_LEG;
      sfcd_pkg::OPC_CONT_LF:  dec_op = sfcd_pkg::SFCD_OP_CONT_RD_LF;
      sfcd_pkg::OPC_CONT_HF:  dec_op = sfcd_pkg::SFCD_OP_CONT_RD_HF;
      sfcd_pkg::OPC_BUF1_RD_LF: dec_op = sfcd_pkg::SFCD_OP_BUF_RD_LF;
      sfcd_pkg::OPC_BUF2_RD_LF: begin
        dec_op = sfcd_pkg::SFCD_OP_BUF_RD_LF;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_BUF1_RD, sfcd_pkg::OPC_LEG_BUF1_RD:
        dec_op = sfcd_pkg::SFCD_OP_BUF_RD;
      sfcd_pkg::OPC_BUF2_RD, sfcd_pkg::OPC_LEG_BUF2_RD: begin
        dec_op = sfcd_pkg::SFCD_OP_BUF_RD;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_BUF1_WR: dec_op = sfcd_pkg::SFCD_OP_BUF_WR;
      sfcd_pkg::OPC_BUF2_WR: begin
        dec_op = sfcd_pkg::SFCD_OP_BUF_WR;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_B1_PROG_E: dec_op = sfcd_pkg::SFCD_OP_PROG_ERASE;
      sfcd_pkg::OPC_B2_PROG_E: begin
        dec_op = sfcd_pkg::SFCD_OP_PROG_ERASE;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_B1_PROG_N: dec_op = sfcd_pkg::SFCD_OP_PROG_NOERASE;
      sfcd_pkg::OPC_B2_PROG_N: begin
        dec_op = sfcd_pkg::SFCD_OP_PROG_NOERASE;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_B1_THRU: dec_op = sfcd_pkg::SFCD_OP_PROG_THRU_BUF;
      sfcd_pkg::OPC_B2_THRU: begin
        dec_op = sfcd_pkg::SFCD_OP_PROG_THRU_BUF;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_B1_XFER: dec_op = sfcd_pkg::SFCD_OP_XFER;
      sfcd_pkg::OPC_B2_XFER: begin
        dec_op = sfcd_pkg::SFCD_OP_XFER;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_B1_CMP: dec_op = sfcd_pkg::SFCD_OP_COMPARE;
      sfcd_pkg::OPC_B2_CMP: begin
        dec_op = sfcd_pkg::SFCD_OP_COMPARE;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_B1_REWR: dec_op = sfcd_pkg::SFCD_OP_REWRITE;
      sfcd_pkg::OPC_B2_REWR: begin
        dec_op = sfcd_pkg::SFCD_OP_REWRITE;
        dec_b2 = 1'b1;
      end
      sfcd_pkg::OPC_PAGE_ERASE:  dec_op = sfcd_pkg::SFCD_OP_PAGE_ERASE;
      sfcd_pkg::OPC_BLOCK_ERASE: dec_op = sfcd_pkg::SFCD_OP_BLOCK_ERASE;
      sfcd_pkg::OPC_SECT_ERASE:  dec_op = sfcd_pkg::SFCD_OP_SECTOR_ERASE;
      sfcd_pkg::OPC_CHIP_ERASE:  dec_op = sfcd_pkg::SFCD_OP_CHIP_ERASE;
      sfcd_pkg::OPC_DEEP_PD:     dec_op = sfcd_pkg::SFCD_OP_DEEP_PD;
      sfcd_pkg::OPC_RESUME:      dec_op = sfcd_pkg::SFCD_OP_RESUME;
      sfcd_pkg::OPC_STATUS, sfcd_pkg::OPC_LEG_STATUS:
        dec_op = sfcd_pkg::SFCD_OP_STATUS_RD;
      sfcd_pkg::OPC_ID:      dec_op = sfcd_pkg::SFCD_OP_ID_RD;
      sfcd_pkg::OPC_PROT_RD: dec_op = sfcd_pkg::SFCD_OP_PROT_RD;
      sfcd_pkg::OPC_LOCK_RD: dec_op = sfcd_pkg::SFCD_OP_LOCK_RD;
      sfcd_pkg::OPC_SEC_PROG: dec_op = sfcd_pkg::SFCD_OP_SEC_PROG;
      sfcd_pkg::OPC_SEC_RD:  dec_op = sfcd_pkg::SFCD_OP_SEC_RD;
      sfcd_pkg::OPC_PROT_PRE0: dec_op = sfcd_pkg::SFCD_OP_NONE;
      default: dec_known = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Protection sequence: the fourth byte selects the operation
  // ------------------------------------------------------------------
  wire prot_pfx_ok = (byte0_reg == sfcd_pkg::OPC_PROT_PRE0);
  wire prot_mid_ok =
    (byte_cnt_reg == 3'h1 && byte_now == sfcd_pkg::OPC_PROT_PRE1) ||
    (byte_cnt_reg == 3'h2 && byte_now == sfcd_pkg::OPC_PROT_PRE2);
  sfcd_pkg::sfcd_op_e prot_op;
  always_comb begin
    case (byte_now)
      sfcd_pkg::OPC_PROT_EN:    prot_op = sfcd_pkg::SFCD_OP_PROT_EN;
      sfcd_pkg::OPC_PROT_DIS:   prot_op = sfcd_pkg::SFCD_OP_PROT_DIS;
      sfcd_pkg::OPC_PROT_ERASE: prot_op = sfcd_pkg::SFCD_OP_PROT_ERASE;
      sfcd_pkg::OPC_PROT_PROG:  prot_op = sfcd_pkg::SFCD_OP_PROT_PROG;
      sfcd_pkg::OPC_LOCKDOWN:   prot_op = sfcd_pkg::SFCD_OP_LOCKDOWN;
      default:                  prot_op = sfcd_pkg::SFCD_OP_NONE;
    endcase
  end

  // ------------------------------------------------------------------
  // Group classification of the decoded operation
  // ------------------------------------------------------------------
  function automatic sfcd_pkg::sfcd_grp_e grp_of(sfcd_pkg::sfcd_op_e op);
    case (op)
      sfcd_pkg::SFCD_OP_PAGE_RD, sfcd_pkg::SFCD_OP_CONT_RD_LEG,
      sfcd_pkg::SFCD_OP_CONT_RD_LF, sfcd_pkg::SFCD_OP_CONT_RD_HF,
      sfcd_pkg::SFCD_OP_PROT_RD, sfcd_pkg::SFCD_OP_LOCK_RD,
      sfcd_pkg::SFCD_OP_SEC_RD:
        grp_of = sfcd_pkg::SFCD_GRP_A;
      sfcd_pkg::SFCD_OP_PAGE_ERASE, sfcd_pkg::SFCD_OP_BLOCK_ERASE,
      sfcd_pkg::SFCD_OP_SECTOR_ERASE, sfcd_pkg::SFCD_OP_CHIP_ERASE,
      sfcd_pkg::SFCD_OP_XFER, sfcd_pkg::SFCD_OP_COMPARE,
      sfcd_pkg::SFCD_OP_PROG_ERASE, sfcd_pkg::SFCD_OP_PROG_NOERASE,
      sfcd_pkg::SFCD_OP_PROG_THRU_BUF, sfcd_pkg::SFCD_OP_REWRITE:
        grp_of = sfcd_pkg::SFCD_GRP_B;
      sfcd_pkg::SFCD_OP_BUF_RD_LF, sfcd_pkg::SFCD_OP_BUF_RD,
      sfcd_pkg::SFCD_OP_BUF_WR, sfcd_pkg::SFCD_OP_STATUS_RD,
      sfcd_pkg::SFCD_OP_ID_RD:
        grp_of = sfcd_pkg::SFCD_GRP_C;
      sfcd_pkg::SFCD_OP_PROT_ERASE, sfcd_pkg::SFCD_OP_PROT_PROG,
      sfcd_pkg::SFCD_OP_LOCKDOWN, sfcd_pkg::SFCD_OP_SEC_PROG:
        grp_of = sfcd_pkg::SFCD_GRP_D;
      sfcd_pkg::SFCD_OP_NONE: grp_of = sfcd_pkg::SFCD_GRP_NONE;
      default: grp_of = sfcd_pkg::SFCD_GRP_PWR;
    endcase
  endfunction : grp_of

  // ------------------------------------------------------------------
  // Frame state: opcode, address and operation held to frame end
  // ------------------------------------------------------------------
  sfcd_pkg::sfcd_op_e op_reg;
  logic               b2_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      byte_cnt_reg <= 3'h0;
      byte0_reg    <= 8'h00;
      byte3_reg    <= 8'h00;
      addr_sr_reg  <= 24'h000000;
      drop_reg     <= 1'b0;
      op_reg       <= sfcd_pkg::SFCD_OP_NONE;
      b2_reg       <= 1'b0;
    end else if (frame_end || cs_n_q_reg) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      drop_reg     <= 1'b0;
      // Cleared so a frame cut before its opcode cannot reissue the last
      op_reg       <= sfcd_pkg::SFCD_OP_NONE;
    end else if (sck_rise && !drop_reg) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= byte_now;
      if (byte_done) begin
        if (byte_cnt_reg != 3'h7)
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        if (first_byte) begin
          byte0_reg <= byte_now;
          op_reg    <= dec_op;
          b2_reg    <= dec_b2;
          drop_reg  <= !dec_known;
        end else if (prot_pfx_ok && byte_cnt_reg < 3'h3) begin
          drop_reg <= !prot_mid_ok;
        end else if (prot_pfx_ok && byte_cnt_reg == 3'h3) begin
          op_reg <= prot_op;
        end else if (byte_cnt_reg <= 3'(sfcd_pkg::ADDR_BYTES)) begin
          addr_sr_reg <= {addr_sr_reg[15:0], byte_now};
        end
        if (byte_cnt_reg == 3'h3)
          byte3_reg <= byte_now;
      end
    end
  end

  // ------------------------------------------------------------------
  // Command issue, busy timer and concurrency gate
  // ------------------------------------------------------------------
  wire  sfcd_pkg::sfcd_grp_e cur_grp = grp_of(op_reg);
  sfcd_pkg::sfcd_grp_e busy_grp_reg;
  logic [15:0]         busy_cnt_reg;
  logic                busy_b2_reg;

  // Group C runs during B; during D only status; buffer clash refused
  wire allow = !busy ||
    (busy_grp_reg == sfcd_pkg::SFCD_GRP_B &&
     cur_grp == sfcd_pkg::SFCD_GRP_C &&
     !(op_reg inside {sfcd_pkg::SFCD_OP_BUF_RD, sfcd_pkg::SFCD_OP_BUF_RD_LF,
                      sfcd_pkg::SFCD_OP_BUF_WR} &&
       b2_reg == busy_b2_reg)) ||
    (busy_grp_reg == sfcd_pkg::SFCD_GRP_D &&
     op_reg == sfcd_pkg::SFCD_OP_STATUS_RD);
  wire issue = frame_end && !drop_reg &&
               op_reg != sfcd_pkg::SFCD_OP_NONE &&
               (!cmd_valid || cmd_ready);
  wire self_timed = cur_grp == sfcd_pkg::SFCD_GRP_B ||
                    cur_grp == sfcd_pkg::SFCD_GRP_D;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_valid    <= 1'b0;
      cmd_op       <= sfcd_pkg::SFCD_OP_NONE;
      cmd_grp      <= sfcd_pkg::SFCD_GRP_NONE;
      cmd_buf2     <= 1'b0;
      cmd_addr     <= 22'h000000;
      cmd_refused  <= 1'b0;
      busy         <= 1'b0;
      busy_cnt_reg <= 16'h0000;
      busy_grp_reg <= sfcd_pkg::SFCD_GRP_NONE;
      busy_b2_reg  <= 1'b0;
    end else begin
      cmd_refused <= issue && !allow;
      if (cmd_valid && cmd_ready)
        cmd_valid <= 1'b0;
      if (issue && allow) begin
        cmd_valid <= 1'b1;
        cmd_op    <= op_reg;
        cmd_grp   <= cur_grp;
        cmd_buf2  <= b2_reg;
        cmd_addr  <= addr_sr_reg[sfcd_pkg::ADDR_W-1:0];
      end
      if (issue && allow && self_timed) begin
        busy         <= 1'b1;
        busy_cnt_reg <= 16'(BUSY_CYCLES);
        busy_grp_reg <= cur_grp;
        busy_b2_reg  <= b2_reg;
      end else if (busy) begin
        busy_cnt_reg <= busy_cnt_reg - 16'h0001;
        if (busy_cnt_reg == 16'h0001)
          busy <= 1'b0;
      end
    end
  end

  // Serial output stays released; data return is outside this decoder
  assign link.miso    = 1'b0;
  assign link.miso_oe = 1'b0;

endmodule : sfcd_device

//--- design/sfcd_host.sv
module sfcd_host (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  sfcd_link_if.host        link,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_byte,
  input  wire logic        req_last,
  output logic             done
);

  // ------------------------------------------------------------------
  // Two-entry skid buffer between requester and shifter
  // ------------------------------------------------------------------
  logic [8:0] buf_mem [2];
  logic       wr_ptr_reg, rd_ptr_reg;
  logic [1:0] cnt_reg;
  wire        buf_full  = (cnt_reg == 2'h2);
  wire        buf_empty = (cnt_reg == 2'h0);
  wire        push      = req_valid && !buf_full;
  logic       pop;

  assign req_ready = !buf_full;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)  rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) buf_mem[wr_ptr_reg] <= {req_last, req_byte};
  end

  // ------------------------------------------------------------------
  // Shifter: SCK is core_clk divided, MSB first, mode 0
  // ------------------------------------------------------------------
  typedef enum {SFCD_H_IDLE, SFCD_H_LOW, SFCD_H_HIGH, SFCD_H_END}
    sfcd_hst_e;
  sfcd_hst_e  st_reg;
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic       last_reg;
  logic [1:0] ph_reg;

  // Each SCK phase lasts SCK_DIV cycles; the far end needs two agreeing
  // samples, so a one-cycle phase would never be seen there
  wire ph_end = (ph_reg == 2'(sfcd_pkg::SCK_DIV - 1));

  assign pop = !buf_empty &&
               (st_reg == SFCD_H_IDLE ||
                (st_reg == SFCD_H_HIGH && ph_end && bit_reg == 3'h7 &&
                 !last_reg));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg    <= SFCD_H_IDLE;
      sh_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      last_reg  <= 1'b0;
      ph_reg    <= 2'h0;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.mosi <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_reg)
        SFCD_H_IDLE: if (pop) begin
          {last_reg, sh_reg} <= buf_mem[rd_ptr_reg];
          link.cs_n <= 1'b0;
          link.mosi <= buf_mem[rd_ptr_reg][7];
          bit_reg   <= 3'h0;
          ph_reg    <= 2'h0;
          st_reg    <= SFCD_H_LOW;
        end
        SFCD_H_LOW: begin
          if (!ph_end) begin
            ph_reg <= ph_reg + 2'h1;
          end else begin
            ph_reg   <= 2'h0;
            link.sck <= 1'b1;
            st_reg   <= SFCD_H_HIGH;
          end
        end
        SFCD_H_HIGH: if (!ph_end) begin
          ph_reg <= ph_reg + 2'h1;
        end else begin
          ph_reg   <= 2'h0;
          link.sck <= 1'b0;
          if (bit_reg != 3'h7) begin
            bit_reg   <= bit_reg + 3'h1;
            link.mosi <= sh_reg[6];
            sh_reg    <= {sh_reg[6:0], 1'b0};
            st_reg    <= SFCD_H_LOW;
          end else if (pop) begin
            {last_reg, sh_reg} <= buf_mem[rd_ptr_reg];
            link.mosi <= buf_mem[rd_ptr_reg][7];
            bit_reg   <= 3'h0;
            st_reg    <= SFCD_H_LOW;
          end else if (last_reg) begin
            st_reg <= SFCD_H_END;
          end
        end
        SFCD_H_END: begin
          link.cs_n <= 1'b1;
          done      <= 1'b1;
          st_reg    <= SFCD_H_IDLE;
        end
        default: st_reg <= SFCD_H_IDLE;
      endcase
    end
  end

endmodule : sfcd_host

//--- bench/sfcd_assertions.sv
module sfcd_assertions (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ------------------------------------------------------------
  // Link framing checks, one clock domain
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Select leads by a low phase, then SCK is high for two cycles
  sequence bit_clk;
    !sck ##1 !sck ##1 sck ##1 sck ##1 !sck;
  endsequence
  chk_no_drive: assert property (!miso_oe)
    else $error("device drove miso");
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("sck moved outside a frame");
  chk_frame_open: assert property ($fell(cs_n) |-> bit_clk)
    else $error("first bit did not follow select");
  chk_sck_pulse: assert property ($rose(sck) |=> sck ##1 !sck)
    else $error("sck high too long");
  chk_mosi_hold: assert property (sck |-> $stable(mosi))
    else $error("mosi moved while sampled");
  chk_frame_gap: assert property ($rose(cs_n) |=> cs_n)
    else $error("frames not separated");
  chk_close_low: assert property ($rose(cs_n) |-> !$past(sck))
    else $error("frame closed with sck high");
  chk_sck_framed: assert property ($rose(sck) |-> $past(!cs_n))
    else $error("sck rose without select");
endmodule : sfcd_assertions

//--- bench/tb_serial_flash_command_decoder.sv
module tb_serial_flash_command_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic                core_clk = 0;
  logic                sys_rst = 1;
  logic                req_valid = 0;
  logic                req_last = 0;
  logic                cmd_ready = 0;
  logic [7:0]          req_byte = 8'h00;
  logic                req_ready, done, cmd_valid, cmd_buf2, busy, cmd_refused;
  logic [21:0]         cmd_addr;
  sfcd_pkg::sfcd_op_e  cmd_op;
  sfcd_pkg::sfcd_grp_e cmd_grp;
  logic [32:0]         exp_q[$];
  bit                  nq[$];
  int                  err_count = 0;
  int                  num_checks = 0;
  // Entry: opcode, op, group, prefix, buffer two, address follows
  logic [23:0] tbl[$] = '{24'hD20111, 24'hE80211, 24'h030311, 24'h0B0411,
    24'h321710, 24'h351810, 24'h520111, 24'h680211,
    24'hD10531, 24'hD30533, 24'hD40631, 24'hD60633, 24'h840731,
    24'h870733, 24'h540631, 24'h560633, 24'hD71D30, 24'h9F1E30,
    24'h571D30, 24'hAB1C50, 24'h830821, 24'h860823, 24'h880921,
    24'h890923, 24'h820E21, 24'h850E23, 24'h810A21, 24'h530F21,
    24'h550F23, 24'h601021, 24'h611023, 24'h581121, 24'h591123,
    24'hCF1444, 24'hFC1544, 24'h301644, 24'h000001,
    24'hB91B50, 24'h7C0C21, 24'h500B21, 24'hC70D20, 24'h771A11,
    24'h9B1941, 24'hA91254, 24'h9A1354};
  sfcd_link_if link ();
  sfcd_host sfcd_host_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link), .req_valid(req_valid), .req_ready(req_ready),
    .req_byte(req_byte), .req_last(req_last), .done(done));
  sfcd_device #(.BUSY_CYCLES(1000)) sfcd_device_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_grp(cmd_grp),
    .cmd_buf2(cmd_buf2), .cmd_addr(cmd_addr), .busy(busy),
    .cmd_refused(cmd_refused));
  sfcd_assertions sfcd_assertions_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
    .miso(link.miso), .miso_oe(link.miso_oe));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // One byte, held until the host takes it
  task automatic put(input logic [7:0] b, input logic last);
    int n = 0;
    req_valid = 1;
    req_byte = b;
    req_last = last;
    do @(posedge core_clk); while (!req_ready && ++n < 300);
    @(negedge core_clk);
    if (last)
      req_valid = 0;
  endtask : put
  // Frame with random address; reserved top bits are random too
  task automatic frame(input logic [23:0] e, input bit ok, input bit hold);
    logic [23:0] a;
    int n = 0;
    a = 24'($urandom);
    // Unknown opcodes give no answer at all, so nothing is noted
    if (e[15:8] != 8'h00) begin
      exp_q.push_back(ok ?
        {1'b0, e[13:8], e[6:4], e[1], a[21:0]} : 33'h100000000);
      nq.push_back(!e[0]);
    end
    if (e[2]) begin
      put(8'h3D, 0);
      put(8'h2A, 0);
      put(8'h7F, 0);
    end
    put(e[23:16], !e[0]);
    for (int i = 2; e[0] && i >= 0; i--) put(a[8*i +: 8], i == 0 && e[23:16] != 8'h0B);
    if (e[23:16] == 8'h0B) put(8'($urandom), 1);
    do @(negedge core_clk); while (!done && ++n < 300);
    repeat (hold ? 16 : 0) @(negedge core_clk);
    while (hold && busy && ++n < 1500) @(negedge core_clk);
  endtask : frame
  // ------------------------------------------------------------
  // Clock, stall, monitor, watchdog, sequence
  // ------------------------------------------------------------
  initial forever #5 core_clk = ~core_clk;
  always @(negedge core_clk) cmd_ready <= $urandom_range(3) != 0;
  always @(posedge core_clk) begin
    logic [32:0] s;
    if ((cmd_valid && cmd_ready) || cmd_refused) begin
      s = cmd_refused ? 33'h100000000 : {1'b0, cmd_op, cmd_grp, cmd_buf2, cmd_addr};
      if (exp_q.size() == 0)
        check(s, 'x);
      else begin
        if (nq.pop_front()) s[21:0] = exp_q[0][21:0];
        check(s, exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h1F260AD4));
    repeat (8) @(negedge core_clk);
    sys_rst = 0;
    foreach (tbl[i]) frame(tbl[i], 1, 1);
    // Busy gate: other buffer passes, same buffer and page read refused; during D status passes, ID refused
    frame(24'h830821, 1, 0);
    frame(24'hD60633, 1, 0);
    frame(24'hD40631, 0, 0);
    frame(24'hD20111, 0, 1);
    frame(24'hCF1444, 1, 0);
    frame(24'hD71D30, 1, 0);
    frame(24'h9F1E30, 0, 1);
    repeat (20) @(negedge core_clk);
    check({32'h0, exp_q.size() != 0}, 33'h0);
    wrap_up();
  end
endmodule : tb_serial_flash_command_decoder
